// ===== design/cprg_core_pointers.sv
// Core pointer registers: stack pointer and the two data pointer bytes.
// Assumes a single clock and an AXI4-Lite master that keeps one write and one read in flight.
//
// Notes on behaviour
// - Push increments stack pointer, then writes value.
// - Reset loads stack pointer with 0x07.
// - Low byte register supplies pointer bits 7..0.
// - Combined pointer addresses external RAM and flash.
// - Undefined addresses are reserved, without function.
`timescale 1ns/1ns
`include "cprg_regs.svh"
module cprg_core_pointers (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [15:0] indirect_data_pointer,
  output logic [7:0] push_addr,
  output logic [7:0] push_data,
  output logic push_strobe
);

  // Write channel state.
  cprg_pkg::cprg_wr_state_t wr_state_reg;
  cprg_pkg::cprg_wr_state_t wr_state_next;
  logic aw_held_reg;
  logic aw_held_next;
  logic w_held_reg;
  logic w_held_next;
  logic [11:0] awaddr_reg;
  logic [11:0] awaddr_next;
  logic [31:0] wdata_reg;
  logic [31:0] wdata_next;
  logic [3:0] wstrb_reg;
  logic [3:0] wstrb_next;
  logic awready_reg;
  logic awready_next;
  logic wready_reg;
  logic wready_next;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;

  // Register update requests toward the byte registers, and their current values.
  logic sp_load;
  logic [7:0] sp_load_value;
  logic dpl_load;
  logic dph_load;
  logic [7:0] sp_value;
  logic [7:0] dpl_value;
  logic [7:0] dph_value;

  // Push port and combined pointer outputs.
  logic [7:0] push_addr_reg;
  logic [7:0] push_addr_next;
  logic [7:0] push_data_reg;
  logic [7:0] push_data_next;
  logic push_strobe_reg;
  logic push_strobe_next;
  logic [15:0] indirect_data_pointer_reg;
  logic [15:0] indirect_data_pointer_next;

  // Read channel state.
  logic arready_reg;
  logic arready_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;

  logic do_write;
  logic [7:0] cmd_byte;

  // The stack pointer and both pointer bytes share one register cell type.
  cprg_byte_reg #(.RESET_VALUE(`CPRG_RST_STACK_TOP)) u_stack_top_pointer (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(sp_load),
    .load_value(sp_load_value),
    .value(sp_value)
  );
  cprg_byte_reg #(.RESET_VALUE(`CPRG_RST_INDIRECT_DATA_POINTER_LOW)) u_data_pointer_low_byte (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(dpl_load),
    .load_value(wdata_reg[7:0]),
    .value(dpl_value)
  );
  cprg_byte_reg #(.RESET_VALUE(`CPRG_RST_INDIRECT_DATA_POINTER_HIGH)) u_data_pointer_high_byte (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(dph_load),
    .load_value(wdata_reg[7:0]),
    .value(dph_value)
  );

  // A write is carried out once both address and data have been taken.
  assign do_write = aw_held_reg && w_held_reg && (wr_state_reg == cprg_pkg::CPRG_WR_IDLE);
  assign cmd_byte = wdata_reg[`CPRG_CMD_DATA_MSB:`CPRG_CMD_DATA_LSB];

  // Write address and data are taken in either order, then answered once.
  always_comb begin
    wr_state_next = wr_state_reg;
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    awready_next = 1'b0;
    wready_next = 1'b0;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_held_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_held_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    unique case (wr_state_reg)
      cprg_pkg::CPRG_WR_IDLE: begin
        if (do_write) begin
          aw_held_next = 1'b0;
          w_held_next = 1'b0;
          bvalid_next = 1'b1;
          bresp_next = `CPRG_RESP_OKAY;
          // Unmapped addresses are reserved: no effect, error answer.
          unique case (awaddr_reg)
            `CPRG_ADDR_STACK_TOP, `CPRG_ADDR_INDIRECT_DATA_POINTER_LOW, `CPRG_ADDR_INDIRECT_DATA_POINTER_HIGH, `CPRG_ADDR_CMD: begin
              bresp_next = `CPRG_RESP_OKAY;
            end
            default: begin
              bresp_next = `CPRG_RESP_SLVERR;
            end
          endcase
          wr_state_next = cprg_pkg::CPRG_WR_RESP;
        end else begin
          // Ready is offered only for a channel not yet holding an item.
          awready_next = !aw_held_next && !awready_reg;
          wready_next = !w_held_next && !wready_reg;
        end
      end
      cprg_pkg::CPRG_WR_RESP: begin
        if (s_axi_bready) begin
          bvalid_next = 1'b0;
          wr_state_next = cprg_pkg::CPRG_WR_IDLE;
        end
      end
      default: begin
        wr_state_next = cprg_pkg::CPRG_WR_IDLE;
      end
    endcase
  end

  // Register loads and the push sequence; byte lane 0 carries register data.
  always_comb begin
    sp_load = 1'b0;
    sp_load_value = sp_value;
    dpl_load = 1'b0;
    dph_load = 1'b0;
    push_addr_next = push_addr_reg;
    push_data_next = push_data_reg;
    push_strobe_next = 1'b0;
    if (do_write) begin
      unique case (awaddr_reg)
        `CPRG_ADDR_STACK_TOP: begin
          sp_load = wstrb_reg[0];
          sp_load_value = wdata_reg[7:0];
        end
        `CPRG_ADDR_INDIRECT_DATA_POINTER_LOW: begin
          dpl_load = wstrb_reg[0];
        end
        `CPRG_ADDR_INDIRECT_DATA_POINTER_HIGH: begin
          dph_load = wstrb_reg[0];
        end
        `CPRG_ADDR_CMD: begin
          if (wdata_reg[`CPRG_CMD_PUSH_BIT] && wstrb_reg[0] && wstrb_reg[1]) begin
            // Increment first, then the value goes to the new top.
            sp_load = 1'b1;
            sp_load_value = sp_value + 8'h01;
            push_addr_next = sp_value + 8'h01;
            push_data_next = cmd_byte;
            push_strobe_next = 1'b1;
          end else if (wdata_reg[`CPRG_CMD_POP_BIT] && wstrb_reg[0]) begin
            // Pop only decrements; nothing is read at the top.
            sp_load = 1'b1;
            sp_load_value = sp_value - 8'h01;
          end
        end
        default: begin
          sp_load = 1'b0;
        end
      endcase
    end
  end

  // The combined pointer is registered so the address output is glitch free.
  always_comb begin
    indirect_data_pointer_next = {dph_value, dpl_value};
  end

  // Read channel: one read at a time, answered one cycle after it is taken.
  always_comb begin
    arready_next = 1'b0;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next = `CPRG_RESP_OKAY;
      rdata_next = 32'h0000_0000;
      unique case (s_axi_araddr)
        `CPRG_ADDR_STACK_TOP: rdata_next = {24'h00_0000, sp_value};
        `CPRG_ADDR_INDIRECT_DATA_POINTER_LOW: rdata_next = {24'h00_0000, dpl_value};
        `CPRG_ADDR_INDIRECT_DATA_POINTER_HIGH: rdata_next = {24'h00_0000, dph_value};
        `CPRG_ADDR_CMD: rdata_next = 32'h0000_0000;
        `CPRG_ADDR_INDIRECT_DATA_POINTER: rdata_next = {16'h0000, dph_value, dpl_value};
        `CPRG_ADDR_PUSH_INFO: rdata_next = {16'h0000, push_data_reg, push_addr_reg};
        default: rresp_next = `CPRG_RESP_SLVERR;
      endcase
    end else if (!rvalid_next && !arready_reg) begin
      arready_next = 1'b1;
    end
  end

  // All state but the three byte registers registered here; outputs come straight from these flops.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= cprg_pkg::CPRG_WR_IDLE;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `CPRG_RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `CPRG_RESP_OKAY;
      push_addr_reg <= 8'h00;
      push_data_reg <= 8'h00;
      push_strobe_reg <= 1'b0;
      indirect_data_pointer_reg <= {`CPRG_RST_INDIRECT_DATA_POINTER_HIGH, `CPRG_RST_INDIRECT_DATA_POINTER_LOW};
    end else begin
      wr_state_reg <= wr_state_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      push_addr_reg <= push_addr_next;
      push_data_reg <= push_data_next;
      push_strobe_reg <= push_strobe_next;
      indirect_data_pointer_reg <= indirect_data_pointer_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign indirect_data_pointer = indirect_data_pointer_reg;
  assign push_addr = push_addr_reg;
  assign push_data = push_data_reg;
  assign push_strobe = push_strobe_reg;
endmodule

// ===== design/cprg_regs.svh
// Register map and constants for the core pointer register block.
// Assumes inclusion by bare name from files under design/.
`ifndef CPRG_REGS_SVH
`define CPRG_REGS_SVH

// Special function register offsets, used as register indexes.
`define CPRG_IDX_STACK_TOP 8'h81
`define CPRG_IDX_INDIRECT_DATA_POINTER_LOW 8'h82
`define CPRG_IDX_INDIRECT_DATA_POINTER_HIGH 8'h83
// Command register index, coined for the sequencer operations.
`define CPRG_IDX_CMD 8'h90
// Byte addresses on the bus are four times the index.
`define CPRG_ADDR_STACK_TOP 12'h204
`define CPRG_ADDR_INDIRECT_DATA_POINTER_LOW 12'h208
`define CPRG_ADDR_INDIRECT_DATA_POINTER_HIGH 12'h20C
`define CPRG_ADDR_CMD 12'h240
`define CPRG_ADDR_INDIRECT_DATA_POINTER 12'h244
`define CPRG_ADDR_PUSH_INFO 12'h248

// Reset values.
`define CPRG_RST_STACK_TOP 8'h07
`define CPRG_RST_INDIRECT_DATA_POINTER_HIGH 8'h00
`define CPRG_RST_INDIRECT_DATA_POINTER_LOW 8'h00

// Command field layout in the command register.
`define CPRG_CMD_PUSH_BIT 0
`define CPRG_CMD_POP_BIT 1
`define CPRG_CMD_DATA_LSB 8
`define CPRG_CMD_DATA_MSB 15

// Bus response codes.
`define CPRG_RESP_OKAY 2'b00
`define CPRG_RESP_SLVERR 2'b10

`endif

// ===== design/cprg_pkg.sv
// Types shared by the core pointer register block.
// Assumes nothing of its surroundings.
package cprg_pkg;
  typedef enum logic [1:0] {
    CPRG_WR_IDLE = 2'b00,
    CPRG_WR_RESP = 2'b01
  } cprg_wr_state_t;
endpackage

// ===== design/cprg_byte_reg.sv
// One byte-wide pointer register with a synchronous reset value.
// Assumes a single clock and a synchronous active-low reset.
`timescale 1ns/1ns
module cprg_byte_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic [7:0] load_value,
  output logic [7:0] value
);
  logic [7:0] value_reg;
  logic [7:0] value_next;

  // The load path replaces the whole byte; reset always wins.
  always_comb begin
    value_next = value_reg;
    if (load) begin
      value_next = load_value;
    end
  end

  // Registering only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value_reg <= RESET_VALUE;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;
endmodule

// ===== bench/cprg_props.sv
// Checker for the core pointer registers, bound to the top module.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module cprg_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] indirect_data_pointer,
  input wire logic push_strobe
);
  logic ar_take, ar_bad;
  // A taken read, and whether its address lies outside the map.
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign ar_bad = !(s_axi_araddr inside {12'h204, 12'h208, 12'h20C, 12'h240, 12'h244, 12'h248});
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_clear: assert property (disable iff (1'b0)
    !aresetn |=> !s_axi_bvalid && indirect_data_pointer == 16'h0000) else $error("reset left state");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
  a_read_answer: assert property (ar_take |=> s_axi_rvalid) else $error("read answer late");
  a_unmapped_read: assert property (
    ar_take && ar_bad |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000) else $error("unmapped read");
  a_ptr_readback: assert property (
    ar_take && s_axi_araddr == 12'h244 |=> s_axi_rdata == {16'h0000, indirect_data_pointer}) else $error("ptr read");
  a_ptr_by_write: assert property (
    $changed(indirect_data_pointer) && $past(aresetn) && $past(aresetn, 2)
    |-> $past(s_axi_bvalid) || s_axi_bvalid) else $error("pointer moved");
  a_push_pulse: assert property (push_strobe |=> !push_strobe) else $error("push held");
  // Main scenarios: a push, a refused write, a stalled read.
  c_push: cover property (push_strobe);
  c_bad_write: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
  c_read_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule
bind cprg_core_pointers cprg_props u_props (.*);

// ===== bench/cprg_seq_model.sv
// Sequencer model: an AXI4-Lite master driven by the bench through two tasks.
// Assumes the bench watchdog cuts any hang; a request line shows junk once taken.
`timescale 1ns/1ns
module cprg_seq_model (
  input wire logic aclk,
  output logic [11:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [11:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // All lines idle at time zero.
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // One write; the answer is accepted only after st stalled cycles.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input int st,
                    output logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (st == 0);
    forever begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
      if (n >= st) s_axi_bready <= 1'b1;
    end
  endtask
  // One read, with the same stall on the answer.
  task automatic rd(input logic [11:0] a, input int st, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (st == 0);
    forever begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
      if (n >= st) s_axi_rready <= 1'b1;
    end
  endtask
endmodule

// ===== bench/cprg_core_pointers_bench.sv
// Self-checking bench for the core pointer registers.
// Assumes the sequencer model stands on the bus side of the block.
`timescale 1ns/1ns
module cprg_core_pointers_bench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, push_strobe;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [15:0] indirect_data_pointer;
  logic [7:0] push_addr, push_data, hi, lo, ph, sp;
  int err_total, cmp_count, pushes;
  cprg_core_pointers dut (.*);
  cprg_seq_model m (.*);
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // A push pulse stands one cycle, so it is counted on its own edge.
  always @(posedge aclk) if (push_strobe === 1'b1) pushes <= pushes + 1;
  function automatic logic [31:0] exp_ptr(input logic [7:0] h, input logic [7:0] l);
    return {16'h0000, h, l};
  endfunction
  function automatic logic [31:0] exp_push(input logic [7:0] v, input logic [7:0] s);
    return {16'h0000, v, s + 8'h01};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bus access with a random stall, checking the response and, for reads, the data.
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    m.rd(a, $urandom_range(2), rd_v, rs);
    chk(rd_v, e);
    chk({30'h0, rs}, {30'h0, er});
  endtask
  task automatic wrc(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    m.wr(a, d, s, $urandom_range(2), rs);
    chk({30'h0, rs}, {30'h0, er});
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog: the tests need a few hundred cycles; this allows two thousand.
  initial begin
    #200_000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(41293));
    aresetn = 1'b0;
    {err_total, cmp_count, pushes} = '0;
    ph = 8'h00;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(12'h204, 32'h0000_0007, 2'b00);
    rdc(12'h20C, 32'h0000_0000, 2'b00);
    rdc(12'h244, 32'h0000_0000, 2'b00);
    $display("test reset values done");
    // Each byte write must leave the other byte of the pointer alone.
    for (int i = 0; i < 4; i++) begin
      hi = (i == 0) ? 8'hFF : 8'($urandom);
      lo = (i == 1) ? 8'hFF : 8'($urandom);
      wrc(12'h208, {24'h00_0000, lo}, 4'hF, 2'b00);
      rdc(12'h244, exp_ptr(ph, lo), 2'b00);
      wrc(12'h20C, {24'h00_0000, hi}, 4'h1, 2'b00);
      rdc(12'h244, exp_ptr(hi, lo), 2'b00);
      chk({16'h0000, indirect_data_pointer}, exp_ptr(hi, lo));
      ph = hi;
    end
    wrc(12'h208, 32'h0000_005A, 4'hE, 2'b00);
    rdc(12'h208, {24'h00_0000, lo}, 2'b00);
    $display("test data pointer done");
    // Pushes start at the wrap point, where pre-increment rolls to zero.
    for (int i = 0; i < 3; i++) begin
      sp = (i == 0) ? 8'hFF : 8'($urandom);
      hi = 8'($urandom);
      wrc(12'h204, {24'h00_0000, sp}, 4'h1, 2'b00);
      wrc(12'h240, {16'h0000, hi, 8'h01}, 4'h3, 2'b00);
      rdc(12'h248, exp_push(hi, sp), 2'b00);
      // The push location and value outputs stand as levels until the next push.
      chk({16'h0000, push_data, push_addr}, exp_push(hi, sp));
      rdc(12'h204, {24'h00_0000, sp + 8'h01}, 2'b00);
    end
    chk(32'(pushes), 32'h0000_0003);
    $display("test push done");
    wrc(12'h210, 32'h0000_0055, 4'hF, 2'b10);
    rdc(12'h210, 32'h0000_0000, 2'b10);
    rdc(12'h204, {24'h00_0000, sp + 8'h01}, 2'b00);
    $display("test reserved address done");
    // A pop steps the stack pointer back to the value it held before the last push.
    wrc(12'h240, 32'h0000_0002, 4'h1, 2'b00);
    rdc(12'h204, {24'h00_0000, sp}, 2'b00);
    rdc(12'h240, 32'h0000_0000, 2'b00);
    $display("test pop done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(12'h204, 32'h0000_0007, 2'b00);
    rdc(12'h244, 32'h0000_0000, 2'b00);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule
